// *** verilog/htxb_pkg.sv ***
// Shared constants and types of the transmit buffer command path.
package htxb_pkg;
	// Device PIO map (byte addresses); data port aliases fill 00h..1Ch.
	localparam logic [2:0]  OFF_DATA_HI    = 3'h0;
	localparam logic [7:0]  OFF_STAT_POP   = 8'h48;
	localparam logic [7:0]  OFF_STAT_PEEK  = 8'h4c;
	localparam logic [7:0]  OFF_INTERRUPT_STATUS_REG    = 8'h58;
	localparam logic [7:0]  OFF_STAT_LEVEL = 8'h64;
	localparam logic [7:0]  OFF_SPACE_INFO = 8'h80;
	// Sizes in words.
	localparam logic [10:0] DATA_FIFO_WORDS = 11'h480;
	localparam logic [7:0]  STAT_FIFO_WORDS = 8'h80;
	// Command A fields.
	localparam int CA_COMPLETION_BIT = 31;
	localparam int CA_RSVD_HI        = 30;
	localparam int CA_RSVD_LO        = 26;
	localparam int CA_ALIGN_HI       = 25;
	localparam int CA_ALIGN_LO       = 24;
	localparam int CA_OFF_HI         = 20;
	localparam int CA_OFF_LO         = 16;
	localparam int CA_FIRST_SEG_BIT  = 13;
	localparam int CA_LAST_SEG_BIT   = 12;
	localparam int CA_BSIZE_HI       = 10;
	localparam int CA_BSIZE_LO       = 0;
	// Command B fields.
	localparam int CB_TAG_HI  = 31;
	localparam int CB_TAG_LO  = 16;
	localparam int CB_PLEN_HI = 10;
	localparam int CB_PLEN_LO = 0;
	// End alignment codes.
	localparam logic [1:0] ALIGN_4  = 2'h0;
	localparam logic [1:0] ALIGN_16 = 2'h1;
	localparam logic [1:0] ALIGN_32 = 2'h2;
	// Status word error bit and interrupt status bits.
	localparam int ST_ERR_BIT        = 15;
	localparam int IS_COMPLETION_BIT = 0;
	localparam int IS_ERROR_BIT      = 1;
	localparam int IS_LEVEL_BIT      = 2;
	localparam logic [2:0] INTERRUPT_STATUS_REG_RST    = 3'h0;
	localparam logic [7:0] STAT_LEVEL_RST = 8'h00;
	// Host APB map.
	localparam logic [7:0] H_CMDA   = 8'h00;
	localparam logic [7:0] H_CMDB   = 8'h04;
	localparam logic [7:0] H_DATA   = 8'h08;
	localparam logic [7:0] H_SPACE  = 8'h0c;
	localparam logic [7:0] H_POP    = 8'h10;
	localparam logic [7:0] H_PEEK   = 8'h14;
	localparam logic [7:0] H_INTSTS = 8'h18;
	localparam logic [7:0] H_LEVEL  = 8'h1c;
	localparam logic [7:0] H_HSTAT  = 8'h20;
	localparam int HS_REFUSED_BIT   = 16;
	localparam logic [10:0] CREDIT_RST = 11'h000;

	typedef enum logic [1:0] {DST_CMDA = 2'b00, DST_CMDB = 2'b01, DST_DATA = 2'b10} htxb_dst_e;
	typedef enum logic [1:0] {HST_IDLE = 2'b00, HST_WAIT = 2'b01, HST_DONE = 2'b10} htxb_hst_e;
	typedef enum logic [1:0] {PH_A = 2'b00, PH_B = 2'b01, PH_DATA = 2'b10} htxb_phase_e;
endpackage : htxb_pkg

// *** verilog/htxb_link_if.sv ***
// PIO link between the host end and the device end.
`timescale 1ns/1ns
interface htxb_link_if;
	logic        pio_wr;
	logic        pio_rd;
	logic [7:0]  pio_addr;
	logic [31:0] pio_wdata;
	logic [31:0] pio_rdata;
	logic        pio_rvalid;
	modport dev (input pio_wr, input pio_rd, input pio_addr, input pio_wdata, output pio_rdata, output pio_rvalid);
	modport hst (output pio_wr, output pio_rd, output pio_addr, output pio_wdata, input pio_rdata, input pio_rvalid);
endinterface : htxb_link_if

// *** verilog/htxb_dev.sv ***
// Device end: command parser, payload trimming, packet checks and status FIFO.
`timescale 1ns/1ns
// Operation
// R1: Each buffer opens with command A, B.
// R2: Host writes A, then B, then payload.
// R3: Packets may span buffers; bits mark boundaries.
// R4: Command B tag copied into status word.
// R5: Differing command B within packet flags error.
// R6: Received byte count must match packet length.
// R7: Payload starts at start offset; earlier bytes dropped.
// R8: Following buffers may start at any byte.
// R9: Alignment padding words accepted, never transmitted.
// R10: Completion bit sets completion flag after load.
// R11: Host writes zero into command A 30:26.
// R12: Status word pushed after every packet. Here none is pushed while 128 are already queued.
// R13: Status level reaching threshold raises flag.
// R14: Host reads space, never writes beyond it.
// R15: Writing into full data FIFO flags error.
// R16: End alignment codes: 4, 16, 32 byte.
// R17: Start offset accepts 0 to 31 bytes.
// R18: Bit 13 marks first segment.
// R19: 48h pops status, 4Ch peeks it.
// R20: One status word per packet, after last. Here none is written while 128 are already queued.
module htxb_dev (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Link to the host end.
	htxb_link_if.dev         link,
	// Transmit side consumer.
	input  wire logic        drain_word,
	output logic             out_valid,
	output logic [31:0]      out_data,
	output logic [3:0]       out_be,
	output logic             out_last,
	// Interrupt status flags.
	output logic [2:0]       interrupt_status_reg
);
	htxb_pkg::htxb_dst_e st_q;
	logic [31:0] cmda_q;
	logic [31:0] pkt_cmdb_q;
	logic        in_pkt_q;
	logic        pkt_err_q;
	logic [11:0] byte_cnt_q;
	logic [9:0]  word_idx_q;
	logic [9:0]  words_q;
	logic [10:0] used_q;
	logic [2:0]  interrupt_status_reg_q;
	logic [7:0]  level_q;
	logic [31:0] stat_mem [128];
	logic [6:0]  wp_q;
	logic [6:0]  rp_q;
	logic [7:0]  scnt_q;
	logic [31:0] rdata_q;
	logic        rvalid_q;
	logic        out_valid_q;
	logic [31:0] out_data_q;
	logic [3:0]  out_be_q;
	logic        out_last_q;

	logic        wr_data_port;
	logic        fifo_full;
	logic        accept;
	logic        overflow;
	logic        drain;
	logic [4:0]  start_off;
	logic [10:0] buf_size;
	logic [11:0] span;
	logic [9:0]  w4;
	logic [9:0]  words_c;
	logic [9:0]  last_idx_c;
	logic [3:0]  be_c;
	logic [11:0] nbytes;
	logic        data_last;
	logic        buf_end;
	logic        pkt_end;
	logic        mismatch;
	logic [31:0] pkt_b;
	logic [11:0] cnt_next;
	logic        err_now;
	logic        final_err;
	logic        push;
	logic        pop;
	logic        stat_empty;
	logic [2:0]  sts_set;
	logic [2:0]  sts_clr;

	assign wr_data_port = link.pio_wr && (link.pio_addr[7:5] == htxb_pkg::OFF_DATA_HI);
	assign fifo_full    = (used_q == htxb_pkg::DATA_FIFO_WORDS);
	assign accept       = wr_data_port && !fifo_full;
	assign overflow     = wr_data_port && fifo_full; // [R15]
	assign drain        = drain_word && (used_q != 11'h000);
	assign start_off    = cmda_q[htxb_pkg::CA_OFF_HI:htxb_pkg::CA_OFF_LO]; // [R17]
	assign buf_size     = cmda_q[htxb_pkg::CA_BSIZE_HI:htxb_pkg::CA_BSIZE_LO];
	assign span         = {7'h00, start_off} + {1'b0, buf_size};
	assign w4           = 10'((span + 12'h003) >> 2);
	assign last_idx_c   = 10'((span - 12'h001) >> 2);

	// Words in the buffer after its commands, padding included.
	always_comb begin
		unique case (cmda_q[htxb_pkg::CA_ALIGN_HI:htxb_pkg::CA_ALIGN_LO])
			htxb_pkg::ALIGN_16: words_c = (w4 + 10'h003) & 10'h3fc; // [R16] [R9]
			htxb_pkg::ALIGN_32: words_c = (w4 + 10'h007) & 10'h3f8; // [R16] [R9]
			default:            words_c = w4;
		endcase
	end

	// A byte lane carries payload only between the start offset and the buffer end.
	for (genvar i = 0; i < 4; i++) begin : g_lane
		logic [11:0] pos;
		assign pos     = {word_idx_q, 2'(i)};
		assign be_c[i] = (pos >= {7'h00, start_off}) && (pos < span); // [R7] [R8] [R9]
	end
	assign nbytes = {11'h000, be_c[0]} + {11'h000, be_c[1]} + {11'h000, be_c[2]} + {11'h000, be_c[3]};

	// The first segment of a buffer opens the packet; a flag bit there is read from command A.
	logic cur_first;
	assign cur_first = cmda_q[htxb_pkg::CA_FIRST_SEG_BIT]; // [R18]
	assign data_last = (word_idx_q == words_q - 10'h001);
	assign buf_end   = accept && (((st_q == htxb_pkg::DST_CMDB) && (words_c == 10'h000)) ||
	                              ((st_q == htxb_pkg::DST_DATA) && data_last));
	assign pkt_end   = buf_end && cmda_q[htxb_pkg::CA_LAST_SEG_BIT]; // [R3] [R20]
	assign mismatch  = accept && (st_q == htxb_pkg::DST_CMDB) && !cur_first &&
	                   (!in_pkt_q || (link.pio_wdata != pkt_cmdb_q)); // [R5]
	assign pkt_b     = ((st_q == htxb_pkg::DST_CMDB) && cur_first) ? link.pio_wdata : pkt_cmdb_q;
	assign cnt_next  = (((st_q == htxb_pkg::DST_CMDB) && cur_first) ? 12'h000 : byte_cnt_q) +
	                   ((st_q == htxb_pkg::DST_DATA) ? nbytes : 12'h000); // [R6]
	assign err_now   = (((st_q == htxb_pkg::DST_CMDB) && cur_first) ? 1'b0 : pkt_err_q) | mismatch;
	assign final_err = err_now | (cnt_next != {1'b0, pkt_b[htxb_pkg::CB_PLEN_HI:htxb_pkg::CB_PLEN_LO]}); // [R6]

	// Command parse: A, then B, then the payload words of the buffer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= htxb_pkg::DST_CMDA;
		end else if (accept) begin
			unique case (st_q)
				htxb_pkg::DST_CMDA: st_q <= htxb_pkg::DST_CMDB; // [R1]
				htxb_pkg::DST_CMDB: st_q <= (words_c == 10'h000) ? htxb_pkg::DST_CMDA : htxb_pkg::DST_DATA;
				htxb_pkg::DST_DATA: st_q <= data_last ? htxb_pkg::DST_CMDA : htxb_pkg::DST_DATA;
				default:            st_q <= htxb_pkg::DST_CMDA;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmda_q     <= 32'h0000_0000;
			words_q    <= 10'h000;
			word_idx_q <= 10'h000;
		end else if (accept) begin
			if (st_q == htxb_pkg::DST_CMDA) begin
				cmda_q <= link.pio_wdata; // [R1]
			end
			if (st_q == htxb_pkg::DST_CMDB) begin
				words_q    <= words_c;
				word_idx_q <= 10'h000;
			end else if (st_q == htxb_pkg::DST_DATA) begin
				word_idx_q <= word_idx_q + 10'h001;
			end
		end
	end

	// Packet state: tag/length of the first buffer, running count and error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pkt_cmdb_q <= 32'h0000_0000;
			in_pkt_q   <= 1'b0;
			pkt_err_q  <= 1'b0;
			byte_cnt_q <= 12'h000;
		end else if (accept && (st_q != htxb_pkg::DST_CMDA)) begin
			pkt_cmdb_q <= pkt_b;
			byte_cnt_q <= cnt_next; // [R8]
			pkt_err_q  <= err_now;
			in_pkt_q   <= !pkt_end;
		end
	end

	// Data FIFO occupancy, freed one word at a time by the consumer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			used_q <= 11'h000;
		end else begin
			used_q <= used_q + {10'h000, accept} - {10'h000, drain};
		end
	end

	// Payload out; all-padding words and skipped offset bytes never appear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid_q <= 1'b0;
			out_data_q  <= 32'h0000_0000;
			out_be_q    <= 4'h0;
			out_last_q  <= 1'b0;
		end else begin
			out_valid_q <= accept && (st_q == htxb_pkg::DST_DATA) && (be_c != 4'h0); // [R9]
			out_data_q  <= link.pio_wdata;
			out_be_q    <= be_c; // [R7]
			out_last_q  <= accept && (st_q == htxb_pkg::DST_DATA) && cmda_q[htxb_pkg::CA_LAST_SEG_BIT] &&
			               (word_idx_q == last_idx_c);
		end
	end

	// Status FIFO: one word per packet while fewer than 128 are queued, written when its last buffer ends.
	assign stat_empty = (scnt_q == 8'h00);
	assign push       = pkt_end && (scnt_q != htxb_pkg::STAT_FIFO_WORDS); // [R12] [R20]
	assign pop        = link.pio_rd && (link.pio_addr == htxb_pkg::OFF_STAT_POP) && !stat_empty; // [R19]

	always_ff @(posedge pclk) begin
		if (push) begin
			stat_mem[wp_q] <= {pkt_b[htxb_pkg::CB_TAG_HI:htxb_pkg::CB_TAG_LO], final_err, 3'h0, cnt_next}; // [R4]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wp_q   <= 7'h00;
			rp_q   <= 7'h00;
			scnt_q <= 8'h00;
		end else begin
			wp_q   <= wp_q + {6'h00, push};
			rp_q   <= rp_q + {6'h00, pop};
			scnt_q <= scnt_q + {7'h00, push} - {7'h00, pop};
		end
	end

	// Status level threshold; zero disables the level flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= htxb_pkg::STAT_LEVEL_RST;
		end else if (link.pio_wr && (link.pio_addr == htxb_pkg::OFF_STAT_LEVEL)) begin
			level_q <= link.pio_wdata[7:0];
		end
	end

	// Sticky flags, write one to clear; a set in the same cycle wins.
	always_comb begin
		sts_set = 3'h0;
		sts_set[htxb_pkg::IS_COMPLETION_BIT] = buf_end && cmda_q[htxb_pkg::CA_COMPLETION_BIT]; // [R10]
		sts_set[htxb_pkg::IS_ERROR_BIT]      = overflow || mismatch || (pkt_end && final_err); // [R5] [R6] [R15]
		sts_set[htxb_pkg::IS_LEVEL_BIT]      = (level_q != 8'h00) && (scnt_q >= level_q); // [R13]
		sts_clr = (link.pio_wr && (link.pio_addr == htxb_pkg::OFF_INTERRUPT_STATUS_REG)) ? link.pio_wdata[2:0] : 3'h0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_status_reg_q <= htxb_pkg::INTERRUPT_STATUS_REG_RST;
		end else begin
			interrupt_status_reg_q <= (interrupt_status_reg_q & ~sts_clr) | sts_set;
		end
	end

	// Register reads answer one cycle after the read strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= link.pio_rd;
			if (link.pio_rd) begin
				unique case (link.pio_addr)
					htxb_pkg::OFF_STAT_POP,
					htxb_pkg::OFF_STAT_PEEK:  rdata_q <= stat_empty ? 32'h0000_0000 : stat_mem[rp_q]; // [R19]
					htxb_pkg::OFF_INTERRUPT_STATUS_REG:    rdata_q <= {29'h0000_0000, interrupt_status_reg_q};
					htxb_pkg::OFF_STAT_LEVEL: rdata_q <= {24'h00_0000, level_q};
					htxb_pkg::OFF_SPACE_INFO: rdata_q <= {21'h00_0000, htxb_pkg::DATA_FIFO_WORDS - used_q};
					default:                  rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign link.pio_rdata       = rdata_q;
	assign link.pio_rvalid      = rvalid_q;
	assign out_valid            = out_valid_q;
	assign out_data             = out_data_q;
	assign out_be               = out_be_q;
	assign out_last             = out_last_q;
	assign interrupt_status_reg = interrupt_status_reg_q;
endmodule : htxb_dev

// *** verilog/htxb_host.sv ***
// Host end: APB register front that issues PIO accesses to the device end.
`timescale 1ns/1ns
module htxb_host (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Link to the device end.
	htxb_link_if.hst         link
);
	htxb_pkg::htxb_hst_e   st_q;
	htxb_pkg::htxb_phase_e phase_q;
	logic        pio_wr_q;
	logic        pio_rd_q;
	logic [7:0]  pio_addr_q;
	logic [31:0] pio_wdata_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [10:0] credit_q;
	logic        refused_q;
	logic        rd_space_q;
	logic        setup;
	logic        is_fifo_wr;
	logic        fifo_ok;

	assign setup      = psel && !penable && (st_q == htxb_pkg::HST_IDLE);
	assign is_fifo_wr = pwrite && ((paddr == htxb_pkg::H_CMDA) || (paddr == htxb_pkg::H_CMDB) ||
	                               (paddr == htxb_pkg::H_DATA));
	// Order A, B, payload and the space credit gate every data port write.
	assign fifo_ok    = (credit_q != 11'h000) &&
	                    (((paddr == htxb_pkg::H_CMDA) && (phase_q != htxb_pkg::PH_B)) ||
	                     ((paddr == htxb_pkg::H_CMDB) && (phase_q == htxb_pkg::PH_B)) ||
	                     ((paddr == htxb_pkg::H_DATA) && (phase_q == htxb_pkg::PH_DATA))); // [R2] [R14]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= htxb_pkg::HST_IDLE;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
			prdata_q   <= 32'h0000_0000;
			pio_wr_q   <= 1'b0;
			pio_rd_q   <= 1'b0;
			rd_space_q <= 1'b0;
		end else begin
			pio_wr_q <= 1'b0;
			pio_rd_q <= 1'b0;
			unique case (st_q)
				htxb_pkg::HST_IDLE: begin
					if (setup && pwrite) begin
						pio_wr_q  <= is_fifo_wr ? fifo_ok :
						             ((paddr == htxb_pkg::H_INTSTS) || (paddr == htxb_pkg::H_LEVEL));
						pslverr_q <= is_fifo_wr && !fifo_ok;
						pready_q  <= 1'b1;
						st_q      <= htxb_pkg::HST_DONE;
					end else if (setup) begin
						if ((paddr == htxb_pkg::H_SPACE) || (paddr == htxb_pkg::H_POP) ||
						    (paddr == htxb_pkg::H_PEEK) || (paddr == htxb_pkg::H_INTSTS) ||
						    (paddr == htxb_pkg::H_LEVEL)) begin
							pio_rd_q   <= 1'b1;
							rd_space_q <= (paddr == htxb_pkg::H_SPACE);
							st_q       <= htxb_pkg::HST_WAIT;
						end else begin
							prdata_q <= (paddr == htxb_pkg::H_HSTAT) ? {15'h0000, refused_q, 5'h00, credit_q} :
							            32'h0000_0000;
							pready_q <= 1'b1;
							st_q     <= htxb_pkg::HST_DONE;
						end
					end
				end
				htxb_pkg::HST_WAIT: begin
					if (link.pio_rvalid) begin
						prdata_q <= link.pio_rdata;
						pready_q <= 1'b1;
						st_q     <= htxb_pkg::HST_DONE;
					end
				end
				htxb_pkg::HST_DONE: begin
					if (psel && penable) begin
						pready_q  <= 1'b0;
						pslverr_q <= 1'b0;
						st_q      <= htxb_pkg::HST_IDLE;
					end
				end
				default: st_q <= htxb_pkg::HST_IDLE;
			endcase
		end
	end

	// Address and data of the next PIO access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pio_addr_q  <= 8'h00;
			pio_wdata_q <= 32'h0000_0000;
		end else if (setup) begin
			unique case (paddr)
				htxb_pkg::H_SPACE:  pio_addr_q <= htxb_pkg::OFF_SPACE_INFO;
				htxb_pkg::H_POP:    pio_addr_q <= htxb_pkg::OFF_STAT_POP;
				htxb_pkg::H_PEEK:   pio_addr_q <= htxb_pkg::OFF_STAT_PEEK;
				htxb_pkg::H_INTSTS: pio_addr_q <= htxb_pkg::OFF_INTERRUPT_STATUS_REG;
				htxb_pkg::H_LEVEL:  pio_addr_q <= htxb_pkg::OFF_STAT_LEVEL;
				default:            pio_addr_q <= 8'h00;
			endcase
			pio_wdata_q <= pwdata;
			if (paddr == htxb_pkg::H_CMDA) begin
				pio_wdata_q[htxb_pkg::CA_RSVD_HI:htxb_pkg::CA_RSVD_LO] <= 5'h00; // [R11]
			end
		end
	end

	// Command phase, space credit and the sticky refusal flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_q   <= htxb_pkg::PH_A;
			credit_q  <= htxb_pkg::CREDIT_RST;
			refused_q <= 1'b0;
		end else begin
			if (setup && is_fifo_wr && fifo_ok) begin
				credit_q <= credit_q - 11'h001; // [R14]
				if (paddr == htxb_pkg::H_CMDA) begin
					phase_q <= htxb_pkg::PH_B; // [R1] [R2]
				end else if (paddr == htxb_pkg::H_CMDB) begin
					phase_q <= htxb_pkg::PH_DATA;
				end
			end else if ((st_q == htxb_pkg::HST_WAIT) && link.pio_rvalid && rd_space_q) begin
				credit_q <= link.pio_rdata[10:0]; // [R14]
			end
			if (setup && is_fifo_wr && !fifo_ok) begin
				refused_q <= 1'b1;
			end else if (setup && pwrite && (paddr == htxb_pkg::H_HSTAT) && pwdata[htxb_pkg::HS_REFUSED_BIT]) begin
				refused_q <= 1'b0;
			end
		end
	end

	assign link.pio_wr    = pio_wr_q;
	assign link.pio_rd    = pio_rd_q;
	assign link.pio_addr  = pio_addr_q;
	assign link.pio_wdata = pio_wdata_q;
	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
endmodule : htxb_host

// *** sim/htxb_chk.sv ***
// Protocol checker for the link between the host end and the device end.
`timescale 1ns/1ns
module htxb_chk (
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// Link signals.
	input wire logic        pio_wr,
	input wire logic        pio_rd,
	input wire logic [7:0]  pio_addr,
	input wire logic [31:0] pio_wdata,
	input wire logic [31:0] pio_rdata,
	input wire logic        pio_rvalid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] rd_addr_q;

	// Remembers which location the pending read asked for.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_addr_q <= 8'h00;
		else if (pio_rd)
			rd_addr_q <= pio_addr;
	end

	AST_RD_ANSWER: assert property (pio_rd |=> pio_rvalid ##1 !(pio_rd || pio_wr) ##1 !(pio_rd || pio_wr))
		else $error("read strobe not answered in the next cycle");
	AST_RVALID_CAUSE: assert property (pio_rvalid |-> $past(pio_rd))
		else $error("read data valid without a read");
	AST_WR_SPACING: assert property (pio_wr |=> !pio_wr && !pio_rd)
		else $error("link strobe right after a write");
	AST_NO_COLLIDE: assert property (!(pio_wr && pio_rd))
		else $error("read and write strobes together");
	AST_RD_MAP: assert property (pio_rd |-> pio_addr inside {8'h48, 8'h4c, 8'h58, 8'h64, 8'h80})
		else $error("read of an unmapped device location");
	AST_WR_MAP: assert property (pio_wr |-> (pio_addr < 8'h20) || (pio_addr inside {8'h58, 8'h64}))
		else $error("write to an unmapped device location");
	AST_SPACE_BOUND: assert property (pio_rvalid && rd_addr_q == 8'h80 |-> pio_rdata <= 32'h480)
		else $error("free space above the data fifo size");
	AST_STAT_FMT: assert property (pio_rvalid && rd_addr_q inside {8'h48, 8'h4c} |-> pio_rdata[14:12] == 3'h0)
		else $error("status word spare bits not zero");
	AST_INTSTS_FMT: assert property (pio_rvalid && rd_addr_q == 8'h58 |-> pio_rdata[31:3] == 29'h0)
		else $error("interrupt status upper bits not zero");

	cover property (pio_wr && pio_addr < 8'h20);
	cover property (pio_rvalid && rd_addr_q == 8'h48 && pio_rdata != 32'h0);
	cover property (pio_rvalid && rd_addr_q == 8'h58 && pio_rdata[1]);
endmodule : htxb_chk

// *** sim/htxb_tb.sv ***
// Self-checking testbench joining the host end and the device end.
`timescale 1ns/1ns
module htxb_tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        drain_word = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        out_valid;
	logic [31:0] out_data;
	logic [3:0]  out_be;
	logic        out_last;
	logic [2:0]  irq_sts;
	logic [36:0] got_q[$];
	logic [36:0] exp_q[$];
	int          n_mismatch = 0;
	int          n_checks = 0;

	htxb_link_if link_if ();
	htxb_host htxb_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_if));
	htxb_dev htxb_dev_inst (.pclk(pclk), .presetn(presetn), .link(link_if), .drain_word(drain_word),
		.out_valid(out_valid), .out_data(out_data), .out_be(out_be), .out_last(out_last),
		.interrupt_status_reg(irq_sts));
	htxb_chk htxb_chk_inst (.pclk(pclk), .presetn(presetn), .pio_wr(link_if.pio_wr), .pio_rd(link_if.pio_rd),
		.pio_addr(link_if.pio_addr), .pio_wdata(link_if.pio_wdata), .pio_rdata(link_if.pio_rdata),
		.pio_rvalid(link_if.pio_rvalid));

	always #50 pclk = ~pclk;

	// Collects payload words and frees each one as it leaves.
	always @(posedge pclk) begin
		drain_word <= out_valid;
		if (out_valid === 1'b1)
			got_q.push_back({out_last, out_be, out_data});
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n >= 100)
			n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		chk({31'h0, e}, {31'h0, err});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r & mask, exp);
	endtask : rd

	// Sends one buffer and queues the payload words it should yield.
	task automatic sendbuf(input logic completion_irq_request, input logic fs, input logic ls, input logic [1:0] al, input int off,
		input int sz, input logic [31:0] cmdb);
		int          nw;
		logic [3:0]  be;
		logic [31:0] d;
		nw = (off + sz + 3) / 4;
		if (al == htxb_pkg::ALIGN_16) nw = (nw + 3) / 4 * 4;
		if (al == htxb_pkg::ALIGN_32) nw = (nw + 7) / 8 * 8;
		wr(htxb_pkg::H_CMDA, {completion_irq_request, 5'h1f, al, 3'h0, 5'(off), 2'h0, fs, ls, 1'h0, 11'(sz)}, 1'b0);
		wr(htxb_pkg::H_CMDB, cmdb, 1'b0);
		for (int i = 0; i < nw; i++) begin
			d = 32'hc0de0000 + 32'(i * 257);
			for (int j = 0; j < 4; j++)
				be[j] = (4 * i + j >= off) && (4 * i + j < off + sz);
			if (be != 4'h0)
				exp_q.push_back({ls && (off + sz - 1) / 4 == i, be, d});
			wr(htxb_pkg::H_DATA, d, 1'b0);
		end
	endtask : sendbuf

	task automatic cmp_out;
		// Lets the collector take the last word, which leaves at the edge where the final write returns.
		@(posedge pclk);
		chk(32'(got_q.size()), 32'(exp_q.size()));
		while (got_q.size() > 0 && exp_q.size() > 0) begin
			chk(got_q[0][31:0], exp_q[0][31:0]);
			chk({27'h0, got_q[0][36:32]}, {27'h0, exp_q[0][36:32]});
			void'(got_q.pop_front());
			void'(exp_q.pop_front());
		end
	endtask : cmp_out

	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(htxb_pkg::H_INTSTS, 32'hffffffff, {29'h0, htxb_pkg::INTERRUPT_STATUS_REG_RST});
		rd(htxb_pkg::H_LEVEL, 32'h000000ff, {24'h0, htxb_pkg::STAT_LEVEL_RST});
		rd(htxb_pkg::H_HSTAT, 32'h000007ff, {21'h0, htxb_pkg::CREDIT_RST});
		wr(htxb_pkg::H_CMDA, 32'h0, 1'b1);
		rd(htxb_pkg::H_SPACE, 32'hffffffff, {21'h0, htxb_pkg::DATA_FIFO_WORDS});
		rd(htxb_pkg::H_HSTAT, 32'h000007ff, {21'h0, htxb_pkg::DATA_FIFO_WORDS});
		wr(htxb_pkg::H_CMDB, 32'h0, 1'b1);
		wr(htxb_pkg::H_DATA, 32'h0, 1'b1);
		rd(htxb_pkg::H_HSTAT, 32'h00010000, 32'h00010000);
		wr(htxb_pkg::H_HSTAT, 32'h00010000, 1'b0);
		rd(htxb_pkg::H_HSTAT, 32'h00010000, 32'h0);
		rd(htxb_pkg::H_POP, 32'hffffffff, 32'h0);
		$display("test reset_and_order done");
		sendbuf(1'b1, 1'b1, 1'b1, htxb_pkg::ALIGN_4, 2, 5, {16'hbeef, 5'h0, 11'd5});
		cmp_out();
		chk({31'h0, irq_sts[htxb_pkg::IS_COMPLETION_BIT]}, 32'h1);
		rd(htxb_pkg::H_INTSTS, 32'h7, 32'h1);
		rd(htxb_pkg::H_PEEK, 32'hffffffff, {16'hbeef, 16'h0005});
		rd(htxb_pkg::H_PEEK, 32'hffffffff, {16'hbeef, 16'h0005});
		rd(htxb_pkg::H_POP, 32'hffffffff, {16'hbeef, 16'h0005});
		rd(htxb_pkg::H_POP, 32'hffffffff, 32'h0);
		wr(htxb_pkg::H_INTSTS, 32'h1, 1'b0);
		rd(htxb_pkg::H_INTSTS, 32'h7, 32'h0);
		$display("test single_buffer done");
		wr(htxb_pkg::H_LEVEL, 32'h1, 1'b0);
		sendbuf(1'b0, 1'b1, 1'b0, htxb_pkg::ALIGN_16, 31, 3, {16'h1234, 5'h0, 11'd5});
		rd(htxb_pkg::H_POP, 32'hffffffff, 32'h0);
		sendbuf(1'b0, 1'b0, 1'b1, htxb_pkg::ALIGN_32, 1, 2, {16'h1234, 5'h0, 11'd5});
		cmp_out();
		rd(htxb_pkg::H_INTSTS, 32'h7, 32'h4);
		rd(htxb_pkg::H_POP, 32'hffffffff, {16'h1234, 16'h0005});
		rd(htxb_pkg::H_POP, 32'hffffffff, 32'h0);
		wr(htxb_pkg::H_LEVEL, 32'h0, 1'b0);
		wr(htxb_pkg::H_INTSTS, 32'h7, 1'b0);
		$display("test split_packet done");
		sendbuf(1'b0, 1'b1, 1'b0, htxb_pkg::ALIGN_4, 0, 4, {16'h1111, 5'h0, 11'd8});
		sendbuf(1'b0, 1'b0, 1'b1, htxb_pkg::ALIGN_4, 0, 4, {16'h2222, 5'h0, 11'd8});
		rd(htxb_pkg::H_INTSTS, 32'h2, 32'h2);
		rd(htxb_pkg::H_POP, 32'h00008000, 32'h00008000);
		wr(htxb_pkg::H_INTSTS, 32'h7, 1'b0);
		rd(htxb_pkg::H_INTSTS, 32'h2, 32'h0);
		sendbuf(1'b0, 1'b1, 1'b1, htxb_pkg::ALIGN_4, 0, 5, {16'h3333, 5'h0, 11'd6});
		rd(htxb_pkg::H_INTSTS, 32'h2, 32'h2);
		rd(htxb_pkg::H_POP, 32'hffff8000, 32'h33338000);
		got_q.delete();
		exp_q.delete();
		$display("test packet_errors done");
		wrap_up();
	end
endmodule : htxb_tb
